//--- inc/ssac_defines.svh
`ifndef SSAC_DEFINES_SVH
`define SSAC_DEFINES_SVH

// register byte offsets
`define SSAC_OFF_MODE      8'h00
`define SSAC_OFF_CFG       8'h04
`define SSAC_OFF_XP        8'h08
`define SSAC_OFF_STAT      8'h0C
`define SSAC_OFF_ISTAT     8'h10
`define SSAC_OFF_IMASK     8'h14

// field positions
`define SSAC_MODE_STRIDE   4
`define SSAC_MODE_W        3
`define SSAC_XP_W          2
`define SSAC_CFG_REP_LSB   0
`define SSAC_CFG_OIN_LSB   4
`define SSAC_CFG_OOUT_LSB  6
`define SSAC_CFG_BSD_LSB   8
`define SSAC_STAT_SUB_LSB  8
`define SSAC_STAT_PRES_LSB 12
`define SSAC_IRQ_XP_BIT    4

// reset values
`define SSAC_CFG_RST       12'h00F
`define SSAC_XP_RST        12'h000
`define SSAC_IMASK_RST     5'h00

// timing
`define SSAC_CLK_MHZ       100
`define SSAC_FLASH_HALF_US 250000

`endif

//--- inc/ssac_pkg.sv
package ssac_pkg;

   typedef enum logic [2:0] {
      auto_pass_mode   = 3'h0,
      auto_retime_mode = 3'h1,
      fixed_3g_mode    = 3'h2,
      fixed_hd_mode    = 3'h3,
      fixed_sd_mode    = 3'h4,
      manual_pass_mode = 3'h5
   } ssac_mode_t;

   typedef enum logic [1:0] {
      rate_unknown = 2'h0,
      rate_270m    = 2'h1,
      rate_1485m   = 2'h2,
      rate_2970m   = 2'h3
   } ssac_rate_t;

   typedef enum logic [1:0] {
      sub_none    = 2'h0,
      sub_dual_rx = 2'h1,
      sub_dual_tx = 2'h2,
      sub_xcvr    = 2'h3
   } ssac_sub_t;

   typedef enum logic [1:0] {
      st_not_monitored = 2'h0,
      st_not_present   = 2'h1,
      st_present       = 2'h2
   } ssac_sig_t;

endpackage : ssac_pkg

//--- hw/ssac_chan_status.sv
module ssac_chan_status (
   // channel setup
   input  ssac_pkg::ssac_mode_t mode,
   input  wire logic            report_en,
   input  wire logic            bypass_sd,
   // detected input
   input  wire logic            present,
   input  ssac_pkg::ssac_rate_t rate,
   input  wire logic            flash,
   // indication and path control
   output logic                 led_present,
   output logic                 led_3g,
   output logic                 led_hd,
   output logic                 led_sd,
   output logic                 pass_raw,
   output logic                 mute,
   output ssac_pkg::ssac_sig_t  state,
   output logic                 slope_upd,
   output logic                 slope_hd
);
   import ssac_pkg::*;

   logic good;
   logic hi_rate;

   always_comb begin
      hi_rate     = (rate == rate_2970m) || (rate == rate_1485m);
      good        = 1'b0;
      led_present = present;
      led_3g      = 1'b0;
      led_hd      = 1'b0;
      led_sd      = 1'b0;
      pass_raw    = 1'b0;
      mute        = 1'b1;
      slope_upd   = 1'b0;
      slope_hd    = 1'b1;
      unique case (mode)
         auto_pass_mode: begin
            good      = present;
            led_3g    = present && (rate == rate_2970m);
            led_hd    = present && (rate == rate_1485m);
            led_sd    = present && (rate == rate_270m);
            pass_raw  = present && (rate == rate_unknown);
            mute      = !present;
            slope_upd = present && (rate != rate_unknown);
            slope_hd  = (rate != rate_270m);
         end
         auto_retime_mode: begin
            good      = present && (rate != rate_unknown);
            led_3g    = present && (rate == rate_2970m);
            led_hd    = present && (rate == rate_1485m);
            led_sd    = present && (rate == rate_270m);
            mute      = !good;
            slope_upd = good;
            slope_hd  = (rate != rate_270m);
         end
         fixed_3g_mode: begin
            good      = present && (rate == rate_2970m);
            led_3g    = good;
            mute      = !good;
            slope_upd = 1'b1;
         end
         fixed_hd_mode: begin
            good      = present && (rate == rate_1485m);
            led_hd    = good;
            mute      = !good;
            slope_upd = 1'b1;
         end
         fixed_sd_mode: begin
            good      = present && (rate == rate_270m);
            led_sd    = good;
            mute      = !good;
            slope_upd = 1'b1;
            slope_hd  = 1'b0;
         end
         manual_pass_mode: begin
            // an absent input leaves every lamp dark and the path muted
            good      = present;
            pass_raw  = present;
            mute      = !present;
            slope_upd = 1'b1;
            slope_hd  = !bypass_sd;
            if (!bypass_sd) begin
               led_3g = present && hi_rate && flash;
               led_hd = present && hi_rate && flash;
            end else begin
               led_sd = present && (rate == rate_270m) && flash;
            end
         end
      endcase
      if (!report_en) begin
         state = st_not_monitored;
      end else if (good) begin
         state = st_present;
      end else begin
         state = st_not_present;
      end
   end

endmodule // ssac_chan_status

//--- hw/ssac_top.sv
// Our own choices: the register addresses and the APB interface to the registers.
`include "ssac_defines.svh"

module ssac_top #(
   parameter int FIBER_VARIANT = 1,
   parameter int FLASH_CYCLES  = `SSAC_FLASH_HALF_US * `SSAC_CLK_MHZ
) (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // detector and strap pins
   input  wire logic [3:0]  in_present,
   input  wire logic [7:0]  in_rate,
   input  wire logic [1:0]  sub_type,
   // per channel indication
   output logic [3:0]       led_present,
   output logic [3:0]       led_3g,
   output logic [3:0]       led_hd,
   output logic [3:0]       led_sd,
   output logic [3:0]       pass_through,
   output logic [3:0]       mute,
   // crosspoint outputs
   output logic [11:0]      out_src,
   output logic [5:0]       out_enable,
   output logic [5:0]       out_slope_hd,
   // interrupt
   output logic             irq
);
   import ssac_pkg::*;

   localparam int NCH = 4;
   localparam int NOUT = 6;
   localparam int SW = 14;
   localparam int CW = $clog2(FLASH_CYCLES + 1);

   generate
      if (FLASH_CYCLES < 2 || FIBER_VARIANT < 0 || FIBER_VARIANT > 1) begin : g_bad
         $error("ssac_top: unsupported parameter value");
      end
   endgenerate

   // input synchroniser, three stages with agreement filter
   logic [SW-1:0] sync1_ff, sync2_ff, sync3_ff, filt_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         sync3_ff <= '0;
      end else begin
         sync1_ff <= {sub_type, in_rate, in_present};
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_ff <= '0;
      end else begin
         for (int b = 0; b < SW; b++) begin
            if (sync2_ff[b] == sync3_ff[b]) begin
               filt_ff[b] <= sync3_ff[b];
            end
         end
      end
   end

   logic [NCH-1:0] present;
   ssac_sub_t      sub;

   assign present = filt_ff[3:0];
   // the two-input coax build has no submodule socket
   assign sub = (FIBER_VARIANT == 1) ? ssac_sub_t'(filt_ff[13:12]) : sub_none;

   // configuration registers
   ssac_mode_t     mode_ff [NCH];
   logic [11:0]    cfg_ff;
   logic [11:0]    xp_ff, nxt_xp;
   logic [5:0]     xp_rej;
   logic [4:0]     irq_stat_ff, nxt_irq_stat;
   logic [4:0]     irq_mask_ff, nxt_irq_mask;
   logic [NCH-1:0] present_d_ff;

   function automatic logic [NCH-1:0] avail_in(input ssac_sub_t s, input logic [1:0] en);
      logic [NCH-1:0] m;
      m = 4'h3;
      if (s == sub_dual_rx) begin
         m[3:2] = en;
      end
      if (s == sub_xcvr) begin
         m[3] = en[1];
      end
      return m;
   endfunction

   function automatic logic [NOUT-1:0] avail_out(input ssac_sub_t s, input logic [1:0] en);
      logic [NOUT-1:0] m;
      m = 6'h0F;
      if (s == sub_dual_tx) begin
         m[5:4] = en;
      end
      if (s == sub_xcvr) begin
         m[5] = en[1];
      end
      return m;
   endfunction

   function automatic logic addr_hit(input logic [7:0] a);
      return (a == `SSAC_OFF_MODE) || (a == `SSAC_OFF_CFG) || (a == `SSAC_OFF_XP) ||
             (a == `SSAC_OFF_STAT) || (a == `SSAC_OFF_ISTAT) || (a == `SSAC_OFF_IMASK);
   endfunction

   logic [NCH-1:0]  av_in;
   logic [NOUT-1:0] av_out;

   // optical ports only count once software enables them
   assign av_in  = avail_in(sub, cfg_ff[`SSAC_CFG_OIN_LSB +: 2]);
   assign av_out = avail_out(sub, cfg_ff[`SSAC_CFG_OOUT_LSB +: 2]);

   // apb: answer in the second access cycle, so prdata is a clean flop
   logic pready_ff, pslverr_ff;
   logic [31:0] prdata_ff, rd_mux;
   logic acc_start, wr_done;

   assign acc_start = psel && penable && !pready_ff;
   assign wr_done   = psel && penable && pready_ff && pwrite;

   // per channel status
   logic [NCH-1:0] ch_lp, ch_l3, ch_lh, ch_ls, ch_pass, ch_mute, ch_upd, ch_shd;
   ssac_sig_t      ch_state [NCH];
   logic           flash_ff;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (paddr == `SSAC_OFF_MODE) begin
         for (int c = 0; c < NCH; c++) begin
            rd_mux[c*`SSAC_MODE_STRIDE +: `SSAC_MODE_W] = mode_ff[c];
         end
      end else if (paddr == `SSAC_OFF_CFG) begin
         rd_mux[11:0] = cfg_ff;
      end else if (paddr == `SSAC_OFF_XP) begin
         rd_mux[11:0] = xp_ff;
      end else if (paddr == `SSAC_OFF_STAT) begin
         for (int c = 0; c < NCH; c++) begin
            rd_mux[c*2 +: 2] = ch_state[c];
         end
         rd_mux[`SSAC_STAT_SUB_LSB +: 2]  = sub;
         rd_mux[`SSAC_STAT_PRES_LSB +: 4] = present;
      end else if (paddr == `SSAC_OFF_ISTAT) begin
         rd_mux[4:0] = irq_stat_ff;
      end else if (paddr == `SSAC_OFF_IMASK) begin
         rd_mux[4:0] = irq_mask_ff;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= 32'h0000_0000;
      end else begin
         pready_ff  <= acc_start;
         pslverr_ff <= acc_start && !addr_hit(paddr);
         prdata_ff  <= (acc_start && !pwrite) ? rd_mux : 32'h0000_0000;
      end
   end

   // a code outside the six modes is ignored, the field keeps its value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int c = 0; c < NCH; c++) begin
            mode_ff[c] <= auto_pass_mode;
         end
      end else if (wr_done && paddr == `SSAC_OFF_MODE) begin
         for (int c = 0; c < NCH; c++) begin
            if (pwdata[c*`SSAC_MODE_STRIDE +: `SSAC_MODE_W] <= 3'h5) begin
               mode_ff[c] <= ssac_mode_t'(pwdata[c*`SSAC_MODE_STRIDE +: `SSAC_MODE_W]);
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_ff <= `SSAC_CFG_RST;
      end else if (wr_done && paddr == `SSAC_OFF_CFG) begin
         cfg_ff <= pwdata[11:0];
      end
   end

   // each output field is checked on its own; a refused field is left alone
   always_comb begin
      nxt_xp = xp_ff;
      xp_rej = 6'h00;
      if (wr_done && paddr == `SSAC_OFF_XP) begin
         for (int o = 0; o < NOUT; o++) begin
            if (av_out[o] && av_in[pwdata[o*2 +: 2]]) begin
               nxt_xp[o*2 +: 2] = pwdata[o*2 +: 2];
            end else begin
               xp_rej[o] = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xp_ff <= `SSAC_XP_RST;
      end else begin
         xp_ff <= nxt_xp;
      end
   end

   // interrupts: set wins over a write-one clear in the same cycle
   always_comb begin
      nxt_irq_stat = irq_stat_ff;
      nxt_irq_mask = irq_mask_ff;
      if (wr_done && paddr == `SSAC_OFF_ISTAT) begin
         nxt_irq_stat = irq_stat_ff & ~pwdata[4:0];
      end
      if (wr_done && paddr == `SSAC_OFF_IMASK) begin
         nxt_irq_mask = pwdata[4:0];
      end
      nxt_irq_stat = nxt_irq_stat | {(|xp_rej), present ^ present_d_ff};
   end

   logic irq_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_ff  <= 5'h00;
         irq_mask_ff  <= `SSAC_IMASK_RST;
         present_d_ff <= 4'h0;
         irq_ff       <= 1'b0;
      end else begin
         irq_stat_ff  <= nxt_irq_stat;
         irq_mask_ff  <= nxt_irq_mask;
         present_d_ff <= present;
         irq_ff       <= |(nxt_irq_stat & nxt_irq_mask);
      end
   end

   // flash timebase
   logic [CW-1:0] flash_cnt_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_cnt_ff <= '0;
         flash_ff     <= 1'b0;
      end else if (flash_cnt_ff == CW'(FLASH_CYCLES - 1)) begin
         flash_cnt_ff <= '0;
         flash_ff     <= !flash_ff;
      end else begin
         flash_cnt_ff <= flash_cnt_ff + 1'b1;
      end
   end

   logic [NCH-1:0] slope_ff;
   logic [NCH-1:0] lp_ff, l3_ff, lh_ff, ls_ff, pass_ff, mute_ff;

   genvar gc;
   generate
      for (gc = 0; gc < NCH; gc++) begin : g_ch
         ssac_chan_status u_stat (
            .mode        (mode_ff[gc]),
            .report_en   (cfg_ff[`SSAC_CFG_REP_LSB + gc]),
            .bypass_sd   (cfg_ff[`SSAC_CFG_BSD_LSB + gc]),
            .present     (present[gc]),
            .rate        (ssac_rate_t'(filt_ff[4 + 2*gc +: 2])),
            .flash       (flash_ff),
            .led_present (ch_lp[gc]),
            .led_3g      (ch_l3[gc]),
            .led_hd      (ch_lh[gc]),
            .led_sd      (ch_ls[gc]),
            .pass_raw    (ch_pass[gc]),
            .mute        (ch_mute[gc]),
            .state       (ch_state[gc]),
            .slope_upd   (ch_upd[gc]),
            .slope_hd    (ch_shd[gc])
         );

         // auto modes keep the last good slope while the rate is unknown
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               slope_ff[gc] <= 1'b1;
            end else if (ch_upd[gc]) begin
               slope_ff[gc] <= ch_shd[gc];
            end
         end

         a_man_flash: assert property (@(posedge pclk) disable iff (!presetn)
            (mode_ff[gc] == manual_pass_mode && present[gc] && !cfg_ff[`SSAC_CFG_BSD_LSB + gc] &&
             filt_ff[5 + 2*gc]) |=> (lp_ff[gc] && pass_ff[gc] && !ls_ff[gc] &&
             l3_ff[gc] == $past(flash_ff) && lh_ff[gc] == $past(flash_ff)))
            else $error("manual high rate indication wrong");

         a_slope_hold: assert property (@(posedge pclk) disable iff (!presetn)
            ((mode_ff[gc] == auto_pass_mode || mode_ff[gc] == auto_retime_mode) &&
             (!present[gc] || filt_ff[4 + 2*gc +: 2] == 2'h0)) |=> $stable(slope_ff[gc]))
            else $error("auto mode slope not held");

         a_dark_absent: assert property (@(posedge pclk) disable iff (!presetn)
            (mode_ff[gc] == manual_pass_mode && !present[gc]) |=>
            (!lp_ff[gc] && !l3_ff[gc] && !lh_ff[gc] && !ls_ff[gc] && mute_ff[gc]))
            else $error("absent input not dark");

         a_unmon_state: assert property (@(posedge pclk) disable iff (!presetn)
            !cfg_ff[`SSAC_CFG_REP_LSB + gc] |-> ch_state[gc] == st_not_monitored)
            else $error("unreported channel not shown as not monitored");

         a_mode_legal: assert property (@(posedge pclk) disable iff (!presetn)
            mode_ff[gc] inside {auto_pass_mode, auto_retime_mode, fixed_3g_mode,
                                fixed_hd_mode, fixed_sd_mode, manual_pass_mode})
            else $error("mode field holds an illegal code");
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lp_ff   <= 4'h0;
         l3_ff   <= 4'h0;
         lh_ff   <= 4'h0;
         ls_ff   <= 4'h0;
         pass_ff <= 4'h0;
         mute_ff <= 4'hF;
      end else begin
         lp_ff   <= ch_lp;
         l3_ff   <= ch_l3;
         lh_ff   <= ch_lh;
         ls_ff   <= ch_ls;
         pass_ff <= ch_pass;
         mute_ff <= ch_mute;
      end
   end

   // crosspoint: several outputs may name one source at once
   logic [11:0]     out_src_ff;
   logic [NOUT-1:0] out_en_ff, out_slope_ff;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         out_src_ff   <= `SSAC_XP_RST;
         out_en_ff    <= 6'h00;
         out_slope_ff <= 6'h00;
      end else begin
         for (int o = 0; o < NOUT; o++) begin
            out_src_ff[o*2 +: 2] <= xp_ff[o*2 +: 2];
            // an output that lost its port or source is switched off
            out_en_ff[o]    <= av_out[o] && av_in[xp_ff[o*2 +: 2]] && !ch_mute[xp_ff[o*2 +: 2]];
            out_slope_ff[o] <= slope_ff[xp_ff[o*2 +: 2]];
         end
      end
   end

   genvar go;
   generate
      for (go = 0; go < NOUT; go++) begin : g_out
         a_en_avail: assert property (@(posedge pclk) disable iff (!presetn)
            out_en_ff[go] |-> $past(av_out[go] && av_in[xp_ff[go*2 +: 2]]))
            else $error("output enabled on unavailable route");

         a_rej_keep: assert property (@(posedge pclk) disable iff (!presetn)
            xp_rej[go] |=> xp_ff[go*2 +: 2] == $past(xp_ff[go*2 +: 2]))
            else $error("refused selection changed the route");

         a_route_follow: assert property (@(posedge pclk) disable iff (!presetn)
            (wr_done && paddr == `SSAC_OFF_XP && !xp_rej[go]) |-> ##2
            out_src_ff[go*2 +: 2] == $past(pwdata[go*2 +: 2], 2))
            else $error("accepted selection not routed");
      end
   endgenerate

   a_opt_in_sub: assert property (@(posedge pclk) disable iff (!presetn)
      av_in[2] |-> sub == sub_dual_rx)
      else $error("optical input one without receiver");

   a_rej_flag: assert property (@(posedge pclk) disable iff (!presetn)
      (|xp_rej) |=> irq_stat_ff[`SSAC_IRQ_XP_BIT])
      else $error("refused selection did not raise its status bit");

   a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      irq_ff == |(irq_stat_ff & irq_mask_ff))
      else $error("interrupt level disagrees with status");

   assign prdata       = prdata_ff;
   assign pready       = pready_ff;
   assign pslverr      = pslverr_ff;
   assign led_present  = lp_ff;
   assign led_3g       = l3_ff;
   assign led_hd       = lh_ff;
   assign led_sd       = ls_ff;
   assign pass_through = pass_ff;
   assign mute         = mute_ff;
   assign out_src      = out_src_ff;
   assign out_enable   = out_en_ff;
   assign out_slope_hd = out_slope_ff;
   assign irq          = irq_ff;

endmodule // ssac_top

//--- verification/ssac_src_model.sv
module ssac_src_model (
   // clock
   input  wire logic       pclk,
   // wanted source state
   input  wire logic [3:0] want_present,
   input  wire logic [7:0] want_rate,
   input  wire logic [1:0] want_sub,
   // detector and strap pins
   output logic [3:0]      in_present,
   output logic [7:0]      in_rate,
   output logic [1:0]      sub_type
);
   timeunit 1ns;
   timeprecision 1ps;
   // one process owns the pins, so they have a single driver
   initial begin
      in_present = 4'h0;
      in_rate    = 8'h00;
      sub_type   = 2'h0;
      // an absent source leaves its rate lines meaningless, so they churn every cycle
      forever begin
         @(posedge pclk);
         in_present <= want_present;
         sub_type   <= want_sub;
         for (int i = 0; i < 4; i++) begin
            in_rate[2*i+:2] <= want_present[i] ? want_rate[2*i+:2] : ~in_rate[2*i+:2];
         end
      end
   end
endmodule // ssac_src_model

//--- verification/testbench.sv
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
   logic [7:0]  paddr, in_rate, w_rate;
   logic [31:0] pwdata, prdata, q;
   logic [3:0]  in_present, w_pres, led_present, led_3g, led_hd, led_sd, pass_through, mute;
   logic [1:0]  sub_type, w_sub, a;
   logic [11:0] out_src;
   logic [5:0]  out_enable, out_slope_hd;
   int          miscompares, n_tests;
   ssac_top #(.FIBER_VARIANT(1), .FLASH_CYCLES(4)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .in_present(in_present), .in_rate(in_rate), .sub_type(sub_type),
      .led_present(led_present), .led_3g(led_3g), .led_hd(led_hd), .led_sd(led_sd),
      .pass_through(pass_through), .mute(mute), .out_src(out_src), .out_enable(out_enable),
      .out_slope_hd(out_slope_hd), .irq(irq));
   ssac_src_model i_src (.pclk(pclk), .want_present(w_pres), .want_rate(w_rate), .want_sub(w_sub),
      .in_present(in_present), .in_rate(in_rate), .sub_type(sub_type));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task final_report;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task apb(input logic wr, input logic [7:0] ad, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1; pwrite <= wr; paddr <= ad; pwdata <= d; penable <= 1'b0;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
      q = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (n >= 20) begin miscompares++; final_report; end
   endtask
   task rd(input logic [7:0] ad, input logic [31:0] e, input string nm);
      apb(1'b0, ad, 32'h0);
      chk(nm, e, q);
   endtask
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0;
      w_pres = 4'h0; w_rate = 8'h00; w_sub = 2'h0; miscompares = 0; n_tests = 0;
      wt(6);
      presetn <= 1'b1;
      rd(8'h04, 32'h00F, "cfg"); rd(8'h08, 32'h0, "xp"); rd(8'h14, 32'h0, "imask"); rd(8'h00, 32'h0, "mode");
      rd(8'h18, 32'h0, "unmapped");
      chk("slverr", 32'h1, {31'h0, err});
      chk("mute", 32'hF, {28'h0, mute});
      $display("test reset done");
      w_pres <= 4'h3; w_rate <= 8'h07;
      wt(8);
      rd(8'h0C, 32'h305A, "stat");
      apb(1'b1, 8'h04, 32'h00E);
      rd(8'h0C, 32'h3058, "stat_off");
      apb(1'b1, 8'h04, 32'h20F);
      $display("test report done");
      for (int c = 0; c < 6; c++) begin
         apb(1'b1, 8'h00, 32'h555 | (c << 12));
         rd(8'h00, 32'h555 | (c << 12), "mode_code");
      end
      apb(1'b1, 8'h00, 32'h6555);
      rd(8'h00, 32'h5555, "mode_bad");
      $display("test modes done");
      wt(8);
      chk("manual", 32'h7C, {24'h0, led_present[2:0], pass_through[1:0], mute[2], led_sd[0], led_hd[1]});
      chk("flash_pair", {31'h0, led_3g[0]}, {31'h0, led_hd[0]});
      a = {led_3g[0], led_sd[1]};
      wt(4);
      chk("flash", {30'h0, ~a}, {30'h0, led_3g[0], led_sd[1]});
      $display("test manual done");
      apb(1'b1, 8'h10, 32'h1F);
      apb(1'b1, 8'h08, 32'h54);
      wt(3);
      chk("xp_src", 32'h54, {20'h0, out_src});
      chk("xp_en", 32'hF, {28'h0, out_enable[3:0]});
      apb(1'b1, 8'h08, 32'h254);
      rd(8'h08, 32'h54, "xp_refused");
      chk("irq_masked", 32'h0, {31'h0, irq});
      apb(1'b1, 8'h14, 32'h10);
      wt(3);
      chk("irq_on", 32'h1, {31'h0, irq});
      apb(1'b1, 8'h10, 32'h10);
      wt(3);
      chk("irq_clr", 32'h0, {31'h0, irq});
      $display("test crosspoint done");
      w_pres <= 4'hF; w_rate <= 8'h87; w_sub <= 2'h2;
      wt(8);
      apb(1'b1, 8'h04, 32'h2CF);
      apb(1'b1, 8'h08, 32'h454);
      wt(3);
      chk("tx_src", 32'h454, {20'h0, out_src});
      chk("tx_en", 32'h3F, {26'h0, out_enable});
      chk("tx_irq", 32'h0, {31'h0, irq});
      w_sub <= 2'h3;
      wt(8);
      apb(1'b1, 8'h04, 32'h2EF);
      apb(1'b1, 8'h08, 32'h457);
      wt(3);
      chk("xcvr_src", 32'h457, {20'h0, out_src});
      chk("xcvr_en", 32'h2F, {26'h0, out_enable});
      $display("test fiber done");
      apb(1'b1, 8'h00, 32'h5505);
      wt(8);
      chk("slope_sd", 32'h0, {31'h0, out_slope_hd[1]});
      w_rate <= 8'h83;
      wt(8);
      chk("slope_held", 32'h0, {31'h0, out_slope_hd[1]});
      w_rate <= 8'h8B;
      wt(8);
      chk("slope_hd", 32'h1, {31'h0, out_slope_hd[1]});
      $display("test slope done");
      w_sub <= 2'h1;
      wt(8);
      apb(1'b1, 8'h04, 32'h23F);
      apb(1'b1, 8'h08, 32'h4E);
      wt(3);
      chk("rx_src", 32'h44E, {20'h0, out_src});
      chk("rx_en", 32'h0F, {26'h0, out_enable});
      $display("test dual rx done");
      apb(1'b1, 8'h00, 32'h5535);
      wt(3);
      chk("fixed_hd", 32'hA, {28'h0, led_present[1], led_3g[1], led_hd[1], mute[1]});
      apb(1'b1, 8'h00, 32'h5525);
      wt(3);
      chk("fixed_3g", 32'h9, {28'h0, led_present[1], led_3g[1], led_hd[1], mute[1]});
      $display("test fixed modes done");
      final_report;
   end
endmodule // testbench
